/* asp_pkg.sv */
// Package for the audio serial configuration and prescaler block
package asp_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ASP_OFF_TXCHK = 8'h18;
  localparam logic [7:0] ASP_OFF_ACFG = 8'h1c;
  localparam logic [7:0] ASP_OFF_ADIV = 8'h20;
  localparam logic [7:0] ASP_OFF_CHKCTL = 8'h24;
  localparam logic [7:0] ASP_OFF_CHKPOLY = 8'h28;

  // ==========================================================
  // Reset values
  localparam logic [15:0] ASP_RST_ACFG = 16'h0000;
  localparam logic [15:0] ASP_RST_ADIV = 16'h0002;
  localparam logic [15:0] ASP_RST_POLY = 16'h0007;
  localparam logic [15:0] ASP_RST_TXCHK = 16'h0000;

  // ==========================================================
  // Field positions of audio_config
  localparam int ASP_B_ASYNC = 12;
  localparam int ASP_B_MODE = 11;
  localparam int ASP_B_EN = 10;
  localparam int ASP_B_ROLE = 8;
  localparam int ASP_B_FSYNC = 7;
  localparam int ASP_B_STD = 4;
  localparam int ASP_B_POL = 3;
  localparam int ASP_B_DLEN = 1;
  localparam int ASP_B_CHANNEL_WIDTH_SELECT = 0;
  localparam logic [15:0] ASP_ACFG_MASK = 16'h1fbf;

  // Field positions of audio_clock_divider
  localparam int ASP_B_MASTER_CLOCK_OUT_ENABLE = 9;
  localparam int ASP_B_ODD = 8;
  localparam logic [15:0] ASP_ADIV_MASK = 16'h03ff;

  // Check control bits
  localparam int ASP_B_CHKEN = 0;
  localparam int ASP_B_CHKLEN = 1;

  // ==========================================================
  // Encodings
  localparam logic [1:0] ASP_STD_I2S = 2'h0;
  localparam logic [1:0] ASP_STD_PCM = 2'h3;
  localparam logic [1:0] ASP_DLEN_16 = 2'h0;

  typedef enum logic [1:0] {
    ASP_ST_IDLE, ASP_ST_WAIT, ASP_ST_RUN
  } asp_start_t;

  typedef struct packed {
    logic       link_clk;
    logic       word_sel;
  } asp_link_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic       wr;
    logic       rd;
  } asp_bus_t;

endpackage : asp_pkg

/* asp_top.sv */
// Configuration, prescaler and transmit check logic of the audio port
// ==========================================================
// Behaviour
// - Running check kept; enable write clears it
// - Check computed bit-serially with programmed polynomial
// - Eight-bit length uses low byte only
// - Sixteen-bit length uses all bits
// - Sync slave start needs clock and edge
// - Async slave start needs clock and level
// - I2S uses falling/low, others rising/high
// - Mode bit picks serial port or audio
// - Audio enable ignored in serial mode
// - Role field: slave/master, transmit/receive
// - Frame sync length only for PCM
// - Standard field selects frame format
// - Polarity bit sets clock idle level
// - Polarity never changes active edge
// - Data length 16/24/32, three forbidden
// - Channel forced 32 unless data 16
// - Master clock out only in master
// - Divide by twice prescaler plus odd
// - Audio settings ignored in serial mode
`timescale 1ns/1ps
module asp_top #(
  parameter int DIV_W = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire asp_pkg::asp_bus_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic tx_bit_valid_i,
  input wire logic tx_bit_i,
  input wire logic busy_i,
  input wire asp_pkg::asp_link_t link_i,
  input wire logic link_edge_i,
  output logic audio_active_o,
  output logic transfer_go_o,
  output logic master_o,
  output logic transmit_o,
  output logic long_sync_o,
  output logic [1:0] std_o,
  output logic [5:0] data_bits_o,
  output logic [5:0] chan_bits_o,
  output logic bit_clk_o,
  output logic mclk_o,
  output logic mclk_oe_n_o
);
  import asp_pkg::*;

  // ==========================================================
  // Registers
  logic [15:0] acfg_ff;
  logic [15:0] adiv_ff;
  logic [15:0] poly_ff;
  logic [1:0] chkctl_ff;
  logic [15:0] txchk_ff;
  logic [15:0] rdata_ff;
  logic [DIV_W:0] div_cnt_ff;
  logic bclk_ff;
  logic mclk_ff;
  logic ws_prev_ff;
  asp_start_t st_ff;

  // Write decode
  wire wr_acfg = bus_i.wr && bus_i.addr == ASP_OFF_ACFG;
  wire wr_adiv = bus_i.wr && bus_i.addr == ASP_OFF_ADIV;
  wire wr_ctl = bus_i.wr && bus_i.addr == ASP_OFF_CHKCTL;
  wire wr_poly = bus_i.wr && bus_i.addr == ASP_OFF_CHKPOLY;
  wire chk_clear = wr_ctl && bus_i.wdata[ASP_B_CHKEN];

  // Field decode
  wire audio_mode = acfg_ff[ASP_B_MODE];
  wire [1:0] role = acfg_ff[ASP_B_ROLE +: 2];
  wire [1:0] std = acfg_ff[ASP_B_STD +: 2];
  wire [1:0] dlen = acfg_ff[ASP_B_DLEN +: 2];
  wire audio_on = audio_mode && acfg_ff[ASP_B_EN];
  wire is_master = role[1];
  wire [DIV_W-1:0] lin_div = adiv_ff[DIV_W-1:0];
  wire odd = adiv_ff[ASP_B_ODD];

  // ==========================================================
  // Configuration outputs, gated by mode
  assign audio_active_o = audio_on;
  assign master_o = audio_mode && is_master;
  assign transmit_o = audio_mode && !role[0];
  assign std_o = audio_mode ? std : 2'h0;
  assign long_sync_o = audio_mode && std == ASP_STD_PCM
                       && acfg_ff[ASP_B_FSYNC];
  assign data_bits_o = !audio_mode ? 6'd0 :
                       dlen == 2'h0 ? 6'd16 :
                       dlen == 2'h1 ? 6'd24 : 6'd32;
  assign chan_bits_o = !audio_mode ? 6'd0 :
                       (dlen == ASP_DLEN_16 && !acfg_ff[ASP_B_CHANNEL_WIDTH_SELECT]) ?
                       6'd16 : 6'd32;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acfg_ff <= ASP_RST_ACFG;
      adiv_ff <= ASP_RST_ADIV;
      poly_ff <= ASP_RST_POLY;
      chkctl_ff <= 2'h0;
    end else begin
      if (wr_acfg) acfg_ff <= bus_i.wdata & ASP_ACFG_MASK;
      if (wr_adiv) adiv_ff <= bus_i.wdata & ASP_ADIV_MASK;
      if (wr_poly) poly_ff <= bus_i.wdata;
      if (wr_ctl) chkctl_ff <= bus_i.wdata[1:0];
    end
  end

  // ==========================================================
  // Bit-serial transmit check; 8-bit mode uses low byte only
  wire len16 = chkctl_ff[ASP_B_CHKLEN];
  wire fb = len16 ? (txchk_ff[15] ^ tx_bit_i)
                  : (txchk_ff[7] ^ tx_bit_i);
  logic [15:0] nxt_txchk;
  always_comb begin
    nxt_txchk = {txchk_ff[14:0], 1'b0} ^ (fb ? poly_ff : 16'h0000);
    if (!len16) nxt_txchk[15:8] = 8'h00;
  end

  // Check register update; enable write clears first
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) txchk_ff <= ASP_RST_TXCHK;
    else if (chk_clear) txchk_ff <= ASP_RST_TXCHK;
    else if (chkctl_ff[ASP_B_CHKEN] && !audio_mode && tx_bit_valid_i)
      txchk_ff <= nxt_txchk;
  end

  // ==========================================================
  // Read mux, data one cycle after strobe
  wire [15:0] rd_mux =
    bus_i.addr == ASP_OFF_TXCHK ? txchk_ff :
    bus_i.addr == ASP_OFF_ACFG ? acfg_ff :
    bus_i.addr == ASP_OFF_ADIV ? adiv_ff :
    bus_i.addr == ASP_OFF_CHKCTL ? {14'h0, chkctl_ff} :
    bus_i.addr == ASP_OFF_CHKPOLY ? poly_ff : 16'h0000;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rdata_ff <= 16'h0000;
    else rdata_ff <= bus_i.rd ? rd_mux : 16'h0000;
  end
  assign rdata_o = rdata_ff;

  // ==========================================================
  // Slave start detection
  wire want_low = std == ASP_STD_I2S;
  wire ws_level = want_low ? !link_i.word_sel : link_i.word_sel;
  wire ws_edge = want_low ? (ws_prev_ff && !link_i.word_sel)
                          : (!ws_prev_ff && link_i.word_sel);
  wire async_en = acfg_ff[ASP_B_ASYNC];
  wire start_ok = async_en ? ws_level : ws_edge;
  asp_start_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ASP_ST_IDLE: if (audio_on && !is_master) nxt_st = ASP_ST_WAIT;
        else if (audio_on) nxt_st = ASP_ST_RUN;
      ASP_ST_WAIT: if (!audio_on) nxt_st = ASP_ST_IDLE;
        else if (link_edge_i && start_ok) nxt_st = ASP_ST_RUN;
      ASP_ST_RUN: if (!audio_on) nxt_st = ASP_ST_IDLE;
      default: nxt_st = ASP_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= ASP_ST_IDLE;
      ws_prev_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (link_edge_i) ws_prev_ff <= link_i.word_sel;
    end
  end
  assign transfer_go_o = st_ff == ASP_ST_RUN;

  // ==========================================================
  // Prescaler: half-period counts alternate to give 2*div+odd
  wire [DIV_W:0] hi_cnt = {1'b0, lin_div};
  wire [DIV_W:0] lo_cnt = {1'b0, lin_div} + {{DIV_W{1'b0}}, odd};
  wire [DIV_W:0] half = bclk_ff ? lo_cnt : hi_cnt;
  wire div_run = audio_on && is_master && st_ff == ASP_ST_RUN;
  wire div_wrap = div_cnt_ff >= half - 1'b1;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_ff <= '0;
      bclk_ff <= 1'b0;
      mclk_ff <= 1'b0;
    end else if (!div_run) begin
      div_cnt_ff <= '0;
      bclk_ff <= 1'b0;
      mclk_ff <= 1'b0;
    end else begin
      mclk_ff <= !mclk_ff;
      if (div_wrap) begin
        div_cnt_ff <= '0;
        bclk_ff <= !bclk_ff;
      end else begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
      end
    end
  end
  // Polarity only inverts the pin; internal edge unchanged
  assign bit_clk_o = bclk_ff ^ (audio_mode && acfg_ff[ASP_B_POL]);
  assign mclk_o = mclk_ff;
  assign mclk_oe_n_o = !(div_run && adiv_ff[ASP_B_MASTER_CLOCK_OUT_ENABLE]);

  // ==========================================================
  // Checks
  chk_clear_wins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    chk_clear |=> txchk_ff == 16'h0000) else $error("clear lost");
  chk_low_byte: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !len16 && !chk_clear |=> txchk_ff[15:8] == 8'h00 || $past(len16) == 1'b0
    && $past(txchk_ff[15:8]) != 8'h00) else $error("high byte set");
  chk_chan_force: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    audio_mode && dlen != ASP_DLEN_16 |-> chan_bits_o == 6'd32)
    else $error("channel not 32");
  chk_mclk_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !is_master |-> mclk_oe_n_o) else $error("mclk in slave");
  chk_serial_ign: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !audio_mode |-> !audio_active_o && std_o == 2'h0)
    else $error("serial not ignoring");
  chk_pcm_sync: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    std != ASP_STD_PCM |-> !long_sync_o) else $error("sync off pcm");
  chk_slave_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_ff == ASP_ST_WAIT && !link_edge_i |=> st_ff != ASP_ST_RUN)
    else $error("start w/o clock");
  chk_div_period: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_bclk_rise_div2 ##1 div_run |=> $fell(bclk_ff) || !div_run)
    else $error("bad divide");

  // ==========================================================
  // Sequences for multi-step checks

  // Slave waiting, active link edge with its start condition
  sequence s_slave_trigger;
    st_ff == ASP_ST_WAIT && audio_on && link_edge_i && start_ok;
  endsequence

  // Bit clock just rose with the smallest legal divider
  sequence s_bclk_rise_div2;
    div_run && $rose(bclk_ff) && lin_div == DIV_W'(2) && !odd;
  endsequence

  // One serial bit enters the running check
  sequence s_bit_step;
    chkctl_ff[ASP_B_CHKEN] && !audio_mode && tx_bit_valid_i && !chk_clear;
  endsequence

  // Synchronous slave start seen on a matching edge
  sequence s_sync_start;
    s_slave_trigger ##0 !async_en && ws_edge;
  endsequence

  // Asynchronous slave start seen on a matching level
  sequence s_async_start;
    s_slave_trigger ##0 async_en && ws_level;
  endsequence

  // ==========================================================
  // Further checks

  // Start condition moves the slave to running
  chk_slave_go: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_slave_trigger |=> st_ff == ASP_ST_RUN)
    else $error("slave start missed");

  // Edge-based start when asynchronous start is off
  chk_sync_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_sync_start |=> transfer_go_o)
    else $error("edge start missed");

  // Level-based start when asynchronous start is on
  chk_async_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_async_start |=> transfer_go_o)
    else $error("level start missed");

  // Each accepted bit advances the check by one step
  chk_check_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_bit_step |=> txchk_ff == $past(nxt_txchk))
    else $error("check step wrong");

  // Check register frozen while in audio mode
  chk_check_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    audio_mode && !chk_clear |=> txchk_ff == $past(txchk_ff))
    else $error("check moved in audio");

  // Disabling stops any running transfer
  chk_go_enable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !audio_on |=> !transfer_go_o)
    else $error("run while disabled");

  // Bit clock returns to its idle level when stopped
  chk_idle_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !div_run |=> !bclk_ff)
    else $error("clock not idle");

  // Master clock toggles every cycle while running
  chk_mclk_toggle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    div_run && $past(div_run) |-> mclk_ff != $past(mclk_ff))
    else $error("mclk stuck");

  // Read data zero outside the answer cycle
  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("stray read data");

  // Configuration read returns the stored value
  chk_read_cfg: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bus_i.rd && bus_i.addr == ASP_OFF_ACFG |=> rdata_o == $past(acfg_ff))
    else $error("config read wrong");

  // Reserved configuration bits never set
  chk_cfg_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (acfg_ff & ~ASP_ACFG_MASK) == 16'h0000)
    else $error("reserved bit set");

  // Medium data length decodes to 24 bits
  chk_data_len: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    audio_mode && dlen == 2'h1 |-> data_bits_o == 6'd24)
    else $error("data length wrong");

  // Standard field passed through in audio mode
  chk_std_sel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    audio_mode |-> std_o == std)
    else $error("standard wrong");

  // Role field gives direction and side
  chk_role_dir: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    audio_mode |-> master_o == role[1] && transmit_o == !role[0])
    else $error("role wrong");
endmodule : asp_top

/* asp_codec.sv */
// Behavioural audio codec on the far side of the serial link
`timescale 1ns/1ps
module asp_codec #(
  parameter int HALF = 2
) (
  input wire logic clk_i,
  input wire logic run_i,
  output asp_pkg::asp_link_t link_o,
  output logic edge_o
);
  import asp_pkg::*;
  // ==========================================================
  // Bit clock runs whenever run_i is high, word select flips per 16 bits
  int cnt_ff = 0;
  int bits_ff = 0;
  // Single driver: idle values come from the stopped branch below
  always @(posedge clk_i) begin
    edge_o <= 1'b0;
    if (!run_i) begin
      link_o <= '{link_clk: 1'b0, word_sel: 1'b1};
      cnt_ff <= 0;
      bits_ff <= 0;
    end else if (cnt_ff == HALF - 1) begin
      cnt_ff <= 0;
      link_o.link_clk <= !link_o.link_clk;
      edge_o <= !link_o.link_clk;
      if (link_o.link_clk) begin
        bits_ff <= (bits_ff + 1) % 16;
        if (bits_ff == 15) link_o.word_sel <= !link_o.word_sel;
      end
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule : asp_codec

/* testbench.sv */
// Self-checking bench for the audio configuration and prescaler block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import asp_pkg::*;
  logic clk_i = 0, arst_n_i = 0, bit_v = 0, bit_d = 0, run = 0, edg;
  asp_bus_t bus = '0;
  asp_link_t lnk;
  logic [15:0] rdata;
  logic act, go, mst, tx, lsync, bclk, mclk, oe_n;
  logic [1:0] std;
  logic [5:0] dbits, cbits;
  int failures = 0, checks = 0, cyc = 0;
  asp_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus),
    .rdata_o(rdata), .tx_bit_valid_i(bit_v), .tx_bit_i(bit_d),
    .busy_i(1'b0), .link_i(lnk), .link_edge_i(edg), .audio_active_o(act),
    .transfer_go_o(go), .master_o(mst), .transmit_o(tx),
    .long_sync_o(lsync), .std_o(std), .data_bits_o(dbits),
    .chan_bits_o(cbits), .bit_clk_o(bclk), .mclk_o(mclk),
    .mclk_oe_n_o(oe_n));
  asp_codec codec (.clk_i(clk_i), .run_i(run), .link_o(lnk), .edge_o(edg));
  // ==========================================================
  // Clock, timeout and closing report
  initial forever #5 clk_i = !clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Reference bit-serial check step
  function automatic logic [15:0] step(input logic [15:0] c, input logic b,
      input logic [15:0] p, input logic w16);
    if (w16) return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
    return {8'h00, c[6:0], 1'b0} ^ ((c[7] ^ b) ? {8'h00, p[7:0]} : 16'h0);
  endfunction : step
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [15:0] v;
    rd(ASP_OFF_TXCHK, v); `CHK(v, 16'h0000)
    rd(ASP_OFF_ACFG, v); `CHK(v, 16'h0000)
    rd(ASP_OFF_ADIV, v); `CHK(v, 16'h0002)
    rd(8'h30, v); `CHK(v, 16'h0000)
    wr(ASP_OFF_ACFG, 16'hffff);
    rd(ASP_OFF_ACFG, v); `CHK(v, 16'h1fbf)
    wr(ASP_OFF_ADIV, 16'hffff);
    rd(ASP_OFF_ADIV, v); `CHK(v, 16'h03ff)
    wr(ASP_OFF_ACFG, 16'h0000);
  endtask : t_regs
  task automatic t_check(input logic w16, input logic [15:0] p,
      input logic [15:0] dat);
    logic [15:0] v, e;
    e = 16'h0000;
    wr(ASP_OFF_CHKPOLY, p);
    wr(ASP_OFF_CHKCTL, {14'h0, w16, 1'b1});
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_i);
      bit_v <= 1'b1;
      bit_d <= dat[i];
      e = step(e, dat[i], p, w16);
    end
    @(posedge clk_i);
    bit_v <= 1'b0;
    rd(ASP_OFF_TXCHK, v); `CHK(v, e)
    if (!w16) `CHK(v[15:8], 8'h00)
    wr(ASP_OFF_CHKCTL, {14'h0, w16, 1'b1});
    rd(ASP_OFF_TXCHK, v); `CHK(v, 16'h0000)
  endtask : t_check
  task automatic t_decode();
    wr(ASP_OFF_ACFG, 16'h0eb2);
    #1 `CHK({act, mst, tx, lsync, std}, 6'h3f)
    `CHK({dbits, cbits}, {6'd24, 6'd32})
    wr(ASP_OFF_ACFG, 16'h0d91);
    #1 `CHK({act, mst, tx, lsync, std}, 6'h21)
    `CHK({dbits, cbits}, {6'd16, 6'd32})
    wr(ASP_OFF_ACFG, 16'h0d10);
    #1 `CHK(cbits, 6'd16)
    wr(ASP_OFF_ACFG, 16'h04b4);
    #1 `CHK({act, std, dbits}, 9'h000)
  endtask : t_decode
  task automatic t_divider();
    int n;
    time t0;
    logic m0;
    wr(ASP_OFF_ACFG, 16'h0000);
    wr(ASP_OFF_ADIV, 16'h0302);
    wr(ASP_OFF_ACFG, 16'h0e00);
    repeat (4) @(posedge clk_i);
    #1 `CHK(oe_n, 1'b0)
    m0 = mclk;
    @(posedge clk_i);
    #1 `CHK(mclk, !m0)
    @(posedge bclk);
    t0 = $time;
    @(posedge bclk);
    n = int'(($time - t0) / 10);
    `CHK(n, 5)
    wr(ASP_OFF_ACFG, 16'h0a00);
    #1 `CHK(oe_n, 1'b1)
  endtask : t_divider
  task automatic t_start(input logic [15:0] cfg, input logic ws);
    int n;
    wr(ASP_OFF_ACFG, 16'h0000);
    run <= 1'b0;
    wr(ASP_OFF_ACFG, cfg);
    run <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1 if (!ws) `CHK(go, 1'b0)
    n = 0;
    while (go !== 1'b1 && n < 400) begin @(posedge clk_i); #1 n++; end
    `CHK({go, lnk.word_sel}, {1'b1, ws})
  endtask : t_start
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1 `CHK({act, go, oe_n}, 3'b001)
    t_regs();
    t_check(1'b0, ASP_RST_POLY, 16'h00a5);
    t_check(1'b1, 16'h8005, 16'h1234);
    t_decode();
    t_divider();
    t_start(16'h0c00, 1'b0);
    t_start(16'h1c10, 1'b1);
    stop_test();
  end
endmodule : testbench
